// ---- hw/hsc_pkg.sv ----
`default_nettype none

package hsc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Core clock period
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Serial clock period when the core is master
    localparam int unsigned SCK_PERIOD_NS = 400;
    // Half serial period in core cycles, least time so round up
    localparam int unsigned SCK_HALF_CYC =
        (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam int unsigned BYTE_BITS = 8;    // Data path width
    localparam int unsigned CS_COUNT = 8;     // Chip-select outputs
    localparam int unsigned TX_DEPTH = 32;    // Transmit FIFO words
    localparam logic [3:0] LAST_EDGE = 4'hf;  // 16th clock edge
    localparam logic [7:0] FILL_BYTE = 8'h00; // Sent on underrun
    // Master sequencer states
    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_RUN = 3'b010,
        M_GAP = 3'b100
    } hsc_mst_e;
endpackage

`default_nettype wire

// ---- hw/hsc_core.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------
// Depth must be a power of two
module hsc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // Storage, no reset needed
    logic [AW:0] wr_q; // Write pointer with wrap bit
    logic [AW:0] rd_q; // Read pointer with wrap bit
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready_o = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o = mem_q[rd_q[AW-1:0]];
    assign push = en_i & in_valid_i & in_ready_o;
    assign pop = en_i & out_valid_o & out_ready_i;

    // Data write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// Serial master/slave core
// ----------------------------------------------------------------
// Contract
// - Runs as master or as slave
// - Mode fault flag can raise interrupt
// - Clock polarity and phase programmable, matched
// - Bit order selectable, LSB or MSB first
// - Byte-wide WISHBONE access for on-chip logic
// - Master drives up to eight chip selects
// - Clock pin output as master, input slave
// - Slave-out line input as master, driven slave only while selected
// - Master-out line driven master, input slave
// - Standby and wake only when enabled
module hsc_core
    import hsc_pkg::*;
#(
    parameter int unsigned HALF_CYC = SCK_HALF_CYC,
    parameter int unsigned NCS = CS_COUNT,
    parameter int unsigned DEPTH = TX_DEPTH
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic core_en_i,
    input wire logic master_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic lsb_first_i,
    input wire logic [$clog2(NCS)-1:0] cs_sel_i,
    input wire logic modf_irq_en_i,
    input wire logic modf_clr_i,
    input wire logic wake_en_i,
    input wire logic stdby_req_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [BYTE_BITS-1:0] wb_dat_i,
    output logic [BYTE_BITS-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic scsn_i,
    output logic [NCS-1:0] csn_o,
    output logic irq_o,
    output logic mode_fault_o,
    output logic busy_o,
    output logic rx_full_o,
    output logic overrun_o,
    output logic cfg_stdby_o,
    output logic cfg_wake_o
);
    localparam logic [7:0] DIV_LOAD = 8'(HALF_CYC - 1);

    // Pick the bit that goes out first
    function automatic logic first_bit(input logic [7:0] b,
                                       input logic lsb);
        first_bit = lsb ? b[0] : b[7];
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins; // {scsn, mosi, miso, sck}
    logic [3:0] s1_q; // First stage, read only by s2_q
    logic [3:0] s2_q; // Safe pin levels
    logic sck_prev_q; // Last sampled clock level
    logic scsn_prev_q; // Last sampled select level

    assign pins = {scsn_i, mosi_i, miso_i, sck_i};

    // Two flops per pin, then edge history
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_q <= 4'h8;
            s2_q <= 4'h8;
            sck_prev_q <= 1'b0;
            scsn_prev_q <= 1'b1;
        end else if (en_i) begin
            s1_q <= pins;
            s2_q <= s1_q;
            sck_prev_q <= s2_q[0];
            scsn_prev_q <= s2_q[3];
        end
    end

    // ------------------------------------------------------------
    // State declarations
    // ------------------------------------------------------------
    hsc_mst_e st_q; // Master sequencer
    logic [7:0] div_q; // Half-period down counter
    logic sck_q; // Master clock level
    logic [NCS-1:0] csn_q; // Chip selects, low active
    logic [3:0] edge_q; // Clock edges within a byte
    logic need_load_q; // Slave owes a reload
    logic [7:0] tx_q; // Transmit shifter
    logic [7:0] rx_sh_q; // Receive shifter
    logic [7:0] rx_q; // Receive holding buffer
    logic out_q; // Serial output bit
    logic rx_full_q, ovr_q, modf_q, irq_q;
    logic ack_q, sck_oe_n_q, mosi_oe_n_q, miso_oe_n_q;
    logic [7:0] dat_q; // Read data to bus
    logic busy_q, stdby_q, wake_q;

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    logic master_on, slave_sel, slv_start, mst_start;
    logic mst_edge, slv_edge, any_edge, lead, sample, shift_ev;
    logic shift_do, load, byte_done, rx_bit, ld_bit;
    logic [7:0] ld_byte, tx_d, rx_d;
    logic fifo_valid, fifo_ready, wr_req, rd_req;
    logic [7:0] fifo_data;

    assign master_on = core_en_i & master_i & ~modf_q;
    assign slave_sel = core_en_i & ~master_i & ~s2_q[3];
    assign slv_start = slave_sel & scsn_prev_q;
    assign mst_start = master_on & (st_q == M_IDLE) & fifo_valid;
    assign mst_edge = (st_q == M_RUN) & (div_q == 8'h00);
    assign slv_edge = slave_sel & (s2_q[0] != sck_prev_q);
    assign any_edge = mst_edge | slv_edge;
    // Leading edge leaves the idle level
    assign lead = master_i ? (sck_q == cpol_i) : (s2_q[0] != cpol_i);
    assign sample = any_edge & (lead != cpha_i);
    assign shift_ev = any_edge & (lead == cpha_i);
    // Phase 1 holds the first bit over edge 0; phase 0 stops at 15
    assign shift_do = shift_ev & ~(cpha_i & (edge_q == 4'h0))
        & ~(~cpha_i & (edge_q == LAST_EDGE));
    // Slave streams bytes back to back while selected
    assign load = mst_start | slv_start | (shift_ev & slave_sel
        & ((cpha_i & (edge_q == 4'h0) & need_load_q)
        | (~cpha_i & (edge_q == LAST_EDGE))));
    assign ld_byte = fifo_valid ? fifo_data : FILL_BYTE;
    assign ld_bit = first_bit(ld_byte, lsb_first_i);
    assign tx_d = lsb_first_i ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    assign rx_bit = master_i ? s2_q[1] : s2_q[2];
    assign rx_d = lsb_first_i ? {rx_bit, rx_sh_q[7:1]}
        : {rx_sh_q[6:0], rx_bit};
    assign byte_done = sample & (edge_q[3:1] == 3'b111);
    assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
    assign rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;

    // Bus writes wait for room, so a full FIFO stalls the bus
    hsc_fifo #(
        .WIDTH(BYTE_BITS),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .en_i(en_i),
        .in_data_i(wb_dat_i),
        .in_valid_i(wr_req),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(load)
    );

    // ------------------------------------------------------------
    // Master sequencer and clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= M_IDLE;
            div_q <= 8'h00;
            sck_q <= 1'b0;
            csn_q <= '1;
        end else if (en_i) begin
            if (!master_on) begin
                // Fault or mode change aborts at once
                st_q <= M_IDLE;
                sck_q <= cpol_i;
                csn_q <= '1;
            end else begin
                unique case (st_q)
                    M_IDLE: begin
                        sck_q <= cpol_i;
                        if (fifo_valid) begin
                            st_q <= M_RUN;
                            div_q <= DIV_LOAD;
                            csn_q <= ~(NCS'(1) << cs_sel_i);
                        end
                    end
                    M_RUN: begin
                        if (div_q == 8'h00) begin
                            sck_q <= ~sck_q;
                            div_q <= DIV_LOAD;
                            if (edge_q == LAST_EDGE) begin
                                st_q <= M_GAP;
                            end
                        end else begin
                            div_q <= div_q - 8'h01;
                        end
                    end
                    M_GAP: begin
                        // Hold select half a period past the last edge
                        if (div_q == 8'h00) begin
                            st_q <= M_IDLE;
                            csn_q <= '1;
                        end else begin
                            div_q <= div_q - 8'h01;
                        end
                    end
                    default: begin
                        st_q <= M_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    // Edge count, cleared at every frame start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            edge_q <= 4'h0;
        end else if (en_i) begin
            if (mst_start || slv_start) begin
                edge_q <= 4'h0;
            end else if (any_edge) begin
                edge_q <= edge_q + 4'h1;
            end
        end
    end

    // Transmit side, buffer is the FIFO behind the shifter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_q <= 8'h00;
            out_q <= 1'b0;
            need_load_q <= 1'b0;
        end else if (en_i) begin
            if (load) begin
                tx_q <= ld_byte;
                out_q <= ld_bit;
                need_load_q <= 1'b0;
            end else if (shift_do) begin
                tx_q <= tx_d;
                out_q <= first_bit(tx_d, lsb_first_i);
            end
            if (byte_done && !load) begin
                need_load_q <= 1'b1;
            end
        end
    end

    // Receive side; set of full wins over a bus read
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_sh_q <= 8'h00;
            rx_q <= 8'h00;
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (en_i) begin
            if (sample) begin
                rx_sh_q <= rx_d;
            end
            if (byte_done) begin
                rx_q <= rx_d;
                rx_full_q <= 1'b1;
                ovr_q <= ovr_q | (rx_full_q & ~rd_req);
            end else if (rd_req) begin
                rx_full_q <= 1'b0;
                ovr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answer, fault, pin drive, power outputs
    // ------------------------------------------------------------
    // Ack one cycle after an accepted request
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            dat_q <= 8'h00;
        end else if (en_i) begin
            ack_q <= (wr_req & fifo_ready) | rd_req;
            if (rd_req) begin
                dat_q <= rx_q;
            end
        end
    end

    // Select seen low while master means another master is active
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            modf_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (en_i) begin
            modf_q <= (core_en_i & master_i & ~s2_q[3])
                | (modf_q & ~modf_clr_i);
            irq_q <= modf_q & modf_irq_en_i;
        end
    end

    // Enables are low active; drop drive the cycle after a change
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_oe_n_q <= 1'b1;
            mosi_oe_n_q <= 1'b1;
            miso_oe_n_q <= 1'b1;
            busy_q <= 1'b0;
        end else if (en_i) begin
            sck_oe_n_q <= ~master_on;
            mosi_oe_n_q <= ~master_on;
            miso_oe_n_q <= ~slave_sel;
            busy_q <= (st_q != M_IDLE) | slave_sel;
        end
    end

    // Power signals stay low unless the feature is enabled
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stdby_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (en_i) begin
            stdby_q <= wake_en_i & stdby_req_i;
            wake_q <= wake_en_i & slv_start;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign sck_o = sck_q;
    assign sck_oe_n_o = sck_oe_n_q;
    assign miso_o = out_q;
    assign miso_oe_n_o = miso_oe_n_q;
    assign mosi_o = out_q;
    assign mosi_oe_n_o = mosi_oe_n_q;
    assign csn_o = csn_q;
    assign irq_o = irq_q;
    assign mode_fault_o = modf_q;
    assign busy_o = busy_q;
    assign rx_full_o = rx_full_q;
    assign overrun_o = ovr_q;
    assign cfg_stdby_o = stdby_q;
    assign cfg_wake_o = wake_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_start;
        en_i && mst_start;
    endsequence
    sequence s_idle2;
        en_i && st_q == M_IDLE ##1 en_i && st_q == M_IDLE;
    endsequence

    property p_mode;
        s_start |=> st_q == M_RUN && !sck_oe_n_o;
    endproperty
    a_mode: assert property (p_mode)
        else $error("master start did not run");
    property p_modf_irq;
        en_i && modf_q && modf_irq_en_i |=> irq_o;
    endproperty
    a_modf_irq: assert property (p_modf_irq)
        else $error("mode fault did not raise irq");
    property p_sck_idle;
        s_idle2 |-> sck_o == $past(cpol_i);
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("idle clock level wrong");
    property p_order;
        en_i && load |=> mosi_o == $past(ld_bit);
    endproperty
    a_order: assert property (p_order)
        else $error("first bit order wrong");
    property p_wb_ack;
        en_i && wr_req && fifo_ready |=> wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("accepted write not acked");
    property p_cs;
        st_q != M_IDLE |-> $onehot(~csn_o);
    endproperty
    a_cs: assert property (p_cs)
        else $error("not exactly one select active");
    property p_slave_sel;
        en_i && s2_q[3] |=> miso_oe_n_o;
    endproperty
    a_slave_sel: assert property (p_slave_sel)
        else $error("slave drove while deselected");
    property p_sck_dir;
        en_i && !master_i |=> sck_oe_n_o && mosi_oe_n_o;
    endproperty
    a_sck_dir: assert property (p_sck_dir)
        else $error("slave drove clock or master-out");
    property p_miso_dir;
        en_i && master_i |=> miso_oe_n_o;
    endproperty
    a_miso_dir: assert property (p_miso_dir)
        else $error("master drove slave-out line");
    property p_wake;
        en_i && !wake_en_i |=> !cfg_wake_o && !cfg_stdby_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("power output while disabled");
    property p_rx;
        en_i && byte_done |=> rx_full_o && rx_q == $past(rx_d);
    endproperty
    a_rx: assert property (p_rx)
        else $error("received byte not buffered");
endmodule

`default_nettype wire

// ---- verification/hsc_slave_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Serial slave chip facing the core in master mode
// ------------------------------------------------------------
module hsc_slave_model (
    input wire logic csn_i, // Select from the core, low
    input wire logic sck_i, // Resolved clock line
    input wire logic mosi_i, // Resolved master-out line
    input wire logic cpha_i, // Phase, same as the core
    input wire logic lsb_first_i, // Order, same as the core
    input wire logic [7:0] tx_i, // Byte handed back
    output logic miso_o, // Slave-out line
    output logic [7:0] rx_o, // Last byte taken in
    output int frames_o // Frames seen so far
);
    int edge_n; // Clock edges in this frame
    int out_n; // Bits sent
    int in_n; // Bits taken
    logic [7:0] sh_q; // Assembly of the incoming byte
    // Bit position of the k-th bit on the wire
    function automatic int pos(input int k);
        return lsb_first_i ? k : 7 - k;
    endfunction
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        frames_o = 0;
        sh_q = 8'h00;
    end
    // Frame start; phase 0 puts bit one out ahead of any edge
    always @(negedge csn_i) begin
        edge_n = 0;
        out_n = 0;
        in_n = 0;
        if (!cpha_i) begin
            miso_o = tx_i[pos(0)];
            out_n = 1;
        end
    end
    // Sample on one edge of each pair, shift on the other
    always @(sck_i) begin
        if (!csn_i) begin
            edge_n = edge_n + 1;
            if ((edge_n % 2 == 1) != cpha_i) begin
                sh_q[pos(in_n)] = mosi_i;
                in_n = in_n + 1;
            end else if (out_n < 8) begin
                miso_o = tx_i[pos(out_n)];
                out_n = out_n + 1;
            end
        end
    end
    // Released line flips so a held value never looks valid
    always @(posedge csn_i) begin
        miso_o = ~miso_o;
        rx_o = sh_q;
        frames_o = frames_o + 1;
    end
endmodule

`default_nettype wire

// ---- verification/test_hsc_core.sv ----
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Bench for the serial core
// ------------------------------------------------------------
module test_hsc_core
    import hsc_pkg::*;
;
    logic clk_i, resetn_i, en_i, core_en_i, master_i, cpol_i, cpha_i;
    logic lsb_first_i, modf_irq_en_i, modf_clr_i, wake_en_i, stdby_req_i;
    logic [2:0] cs_sel_i; // Active chip select
    logic wb_cyc_i, wb_stb_i, wb_we_i, scsn_i, b_sck, b_mosi, m_miso;
    logic [7:0] wb_dat_i, wb_dat_o, csn_o, m_tx, m_rx;
    logic wb_ack_o, sck_o, sck_oe_n_o, miso_o, miso_oe_n_o, mosi_o;
    logic mosi_oe_n_o, irq_o, mode_fault_o, busy_o, rx_full_o, overrun_o;
    logic cfg_stdby_o, cfg_wake_o, ok;
    logic [7:0] got, seen;
    int num_errors = 0, tests_run = 0, wakes = 0, m_frames, f0;
    // Pin levels resolved from the core's output enables
    wire logic sck_i = !sck_oe_n_o ? sck_o : b_sck;
    wire logic miso_i = !miso_oe_n_o ? miso_o : m_miso;
    wire logic mosi_i = !mosi_oe_n_o ? mosi_o : b_mosi;

    hsc_core DUT (
        .clk_i, .resetn_i, .en_i, .core_en_i, .master_i, .cpol_i,
        .cpha_i, .lsb_first_i, .cs_sel_i, .modf_irq_en_i, .modf_clr_i,
        .wake_en_i, .stdby_req_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sck_i, .sck_o, .sck_oe_n_o,
        .miso_i, .miso_o, .miso_oe_n_o, .mosi_i, .mosi_o, .mosi_oe_n_o,
        .scsn_i, .csn_o, .irq_o, .mode_fault_o, .busy_o, .rx_full_o,
        .overrun_o, .cfg_stdby_o, .cfg_wake_o
    );
    hsc_slave_model partner (
        .csn_i(csn_o[cs_sel_i]), .sck_i, .mosi_i, .cpha_i, .lsb_first_i,
        .tx_i(m_tx), .miso_o(m_miso), .rx_o(m_rx), .frames_o(m_frames)
    );

    // ------------------------------------------------------------
    // Clock, wake pulse counter, watchdog
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (cfg_wake_o === 1'b1) wakes++;
    end
    // Whole run needs about 3500 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] act);
        tests_run++;
        if (act !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, act);
        end
    endtask
    // One bus cycle; gives up after lim cycles without ack
    task automatic wb_xfer(input logic we, input logic [7:0] d,
                           input int lim, output logic ack,
                           output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < lim);
        ack = (wb_ack_o === 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Send one byte as master and check both directions
    task automatic master_byte(input logic [7:0] d, input logic [7:0] b);
        int n;
        n = 0;
        m_tx = b;
        wb_xfer(1'b1, d, 100, ok, got);
        while (csn_o === 8'hff && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("csn", ~(8'h01 << cs_sel_i), csn_o);
        chk("drives", 8'h00, {6'h0, sck_oe_n_o, mosi_oe_n_o});
        while (csn_o !== 8'hff && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        chk("slave rx", d, m_rx);
        wb_xfer(1'b0, 8'h00, 100, ok, got);
        chk("master rx", b, got);
        chk("sck idle", {7'h0, cpol_i}, {7'h0, sck_o});
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn_i, core_en_i, cpol_i, cpha_i, lsb_first_i} = 5'h00;
        {modf_irq_en_i, modf_clr_i, wake_en_i, stdby_req_i} = 4'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, b_sck, b_mosi} = 5'h00;
        {en_i, master_i, scsn_i} = 3'h7;
        cs_sel_i = 3'h0;
        wb_dat_i = 8'h00;
        m_tx = 8'h00;
        repeat (3) @(posedge clk_i);
        chk("csn reset", 8'hff, csn_o);
        chk("oe reset", 8'h07, {5'h0, sck_oe_n_o, miso_oe_n_o, mosi_oe_n_o});
        resetn_i <= 1'b1;
        core_en_i <= 1'b1;
        // Every polarity, phase, order and select
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            cpol_i <= i[0];
            cpha_i <= i[1];
            lsb_first_i <= i[2];
            cs_sel_i <= i[2:0];
            repeat (4) @(posedge clk_i);
            master_byte(8'h96 ^ 8'(i * 17), 8'h5a ^ 8'(i * 7));
        end
        // Slave select pulled low while master: mode fault
        scsn_i <= 1'b0;
        modf_irq_en_i <= 1'b1;
        repeat (8) @(negedge clk_i);
        chk("fault", 8'h03, {6'h0, mode_fault_o, irq_o});
        chk("fault drives", 8'hff, {csn_o[7:1], mosi_oe_n_o});
        @(posedge clk_i);
        modf_irq_en_i <= 1'b0;
        scsn_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        chk("fault masked", 8'h02, {6'h0, mode_fault_o, irq_o});
        @(posedge clk_i);
        modf_clr_i <= 1'b1;
        @(posedge clk_i);
        modf_clr_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk("fault clear", 8'h00, {7'h0, mode_fault_o});
        // Fill the FIFO with the core idle, then a stalled write
        @(posedge clk_i);
        core_en_i <= 1'b0;
        f0 = m_frames;
        for (int i = 0; i < TX_DEPTH; i++) wb_xfer(1'b1, 8'(i), 100, ok, got);
        wb_xfer(1'b1, 8'hee, 60, ok, got);
        chk("full stall", 8'h00, {7'h0, ok});
        core_en_i <= 1'b1;
        wb_xfer(1'b1, 8'hee, 200, ok, got);
        chk("late ack", 8'h01, {7'h0, ok});
        repeat (2600) @(negedge clk_i);
        chk("frames", 8'd33, 8'(m_frames - f0));
        chk("last byte", 8'hee, m_rx);
        chk("overrun", 8'h01, {7'h0, overrun_o});
        wb_xfer(1'b0, 8'h00, 100, ok, got);
        @(negedge clk_i);
        chk("overrun read", 8'h00, {7'h0, overrun_o});
        // Standby follows the request only when wake is enabled
        @(posedge clk_i);
        stdby_req_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("stdby off", 8'h00, {7'h0, cfg_stdby_o});
        @(posedge clk_i);
        wake_en_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk("stdby on", 8'h01, {7'h0, cfg_stdby_o});
        // Slave mode, bench plays the external master at 400 ns
        @(posedge clk_i);
        master_i <= 1'b0;
        {cpol_i, cpha_i, lsb_first_i} <= 3'h0;
        wb_xfer(1'b1, 8'hc3, 100, ok, got);
        wakes = 0;
        repeat (4) @(negedge clk_i);
        chk("unselected", 8'h01, {7'h0, miso_oe_n_o});
        @(posedge clk_i);
        scsn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("selected", 8'h02, {6'h0, busy_o, miso_oe_n_o});
        for (int k = 7; k >= 0; k--) begin
            b_mosi <= 1'(8'h69 >> k);
            b_sck <= 1'b0;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            seen[k] = miso_o;
            @(posedge clk_i);
            b_sck <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        b_sck <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk("rx full", 8'h01, {7'h0, rx_full_o});
        chk("slave out", 8'hc3, seen);
        chk("wake", 8'h01, 8'(wakes));
        @(posedge clk_i);
        scsn_i <= 1'b1;
        wb_xfer(1'b0, 8'h00, 100, ok, got);
        chk("slave in", 8'h69, got);
        repeat (6) @(negedge clk_i);
        chk("released", 8'h01, {6'h0, busy_o, miso_oe_n_o});
        end_sim();
    end
endmodule

`default_nettype wire
